//--- core/pvc_pkg.sv
/*
 * constants, field layouts and carriers for the capture register bank.
 * assumes an upstream bus core that hands over one decoded access per cycle.
 */
// What this block does
// (RULE1) max-latency field reads fixed 0x28
// (RULE2) min-grant field reads fixed 0x10
// (RULE3) interrupt pin field reads fixed 0x01
// (RULE4) interrupt line byte stores and returns writes
// (RULE5) two compat enables at 0x40, shared, reset 0
// (RULE6) subsystem vendor writes need enable bit 0
// (RULE7) local window decoded by address bits 11:2
// (RULE8) any access, any byte enables, always accepted
// (RULE9) local data on lane 0, upper lanes zero
// (RULE10) registers four bytes apart, unused reserved
// (RULE11) field-based registers switch on internal field
// (RULE12) status resets zero, overflows and pll unlock sticky, rest live
// (RULE13) presence drops after 31 lines without sync
// (RULE14) horizontal lock needs 32 line run, unwritable
// (RULE15) field bit: odd 0, even 1
// (RULE16) overflow bits set, cleared by write/reset
// (RULE17) line count bit needs 32 matching fields
// (RULE18) pll unlock bit, software polls and clears
// (RULE19) fixed config fields ignore writes
package pvc_pkg;
    localparam logic [6:0]  MAX_LAT_VAL  = 7'h28;
    localparam logic [8:0]  MIN_GNT_VAL  = 9'h010;
    localparam logic [7:0]  INT_PIN_VAL  = 8'h01;

    localparam logic [11:0] CFG_SUBSYS   = 12'h020;
    localparam logic [11:0] CFG_INTLAT   = 12'h03c;
    localparam logic [11:0] CFG_DEVCTL   = 12'h040;
    localparam logic [11:0] LOC_STATUS   = 12'h000;
    localparam logic [11:0] LOC_CAPT_EV  = 12'h010;
    localparam logic [11:0] LOC_CAPT_OD  = 12'h090;

    localparam int ST_PRESENT = 7;
    localparam int ST_LOCK    = 6;
    localparam int ST_FIELD   = 5;
    localparam int ST_LINES   = 4;
    localparam int ST_PLL     = 2;
    localparam int ST_LUMA    = 1;
    localparam int ST_CHROMA  = 0;
    localparam int DC_CMP_A   = 2;
    localparam int DC_CMP_B   = 1;
    localparam int DC_SVWE    = 0;

    localparam logic [7:0]  STATUS_RST   = 8'h00;
    localparam logic [5:0]  RUN_LEN      = 6'h20;
    localparam logic [5:0]  MISS_LIMIT   = 6'h1f;

    typedef struct packed {
        logic        valid;
        logic        cfg;
        logic        write;
        logic        func;
        logic [9:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } pvc_req_t;

    typedef struct packed {
        logic line_tick;
        logic line_had_sync;
        logic line_in_window;
        logic field_end;
        logic field_is_625;
        logic field_even;
        logic pll_unlock;
        logic luma_ovf;
        logic chroma_ovf;
    } pvc_dec_t;

    function automatic logic pvc_hit(input logic [9:0] a, input logic [11:0] off);
        return a == off[11:2];
    endfunction : pvc_hit

    // run-length filter step: count events that disagree with the held state
    function automatic logic [5:0] pvc_run(input logic [5:0] cnt, input logic differs);
        return differs ? cnt + 6'h01 : 6'h00;
    endfunction : pvc_run
endpackage : pvc_pkg

//--- core/pvc_vid_filter.sv
/*
 * slow status filters: video presence, horizontal lock, line standard.
 * assumes line and field strobes are one-cycle pulses on core_clk.
 */
module pvc_vid_filter (
    input  wire logic              core_clk,
    input  wire logic              nrst,
    input  wire pvc_pkg::pvc_dec_t dec,
    output logic                   present_reg,
    output logic                   hlock_reg,
    output logic                   lines625_reg
);
    logic [5:0] miss_reg;
    logic [5:0] hrun_reg;
    logic [5:0] frun_reg;
    logic [5:0] hrun_next;
    logic [5:0] frun_next;

    assign hrun_next = pvc_pkg::pvc_run(hrun_reg, dec.line_in_window != hlock_reg);
    assign frun_next = pvc_pkg::pvc_run(frun_reg, dec.field_is_625 != lines625_reg);

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            miss_reg    <= 6'h00;
            present_reg <= 1'b0;
        end else if (dec.line_tick) begin
            if (dec.line_had_sync) begin
                miss_reg    <= 6'h00;
                present_reg <= 1'b1;
            end else if (miss_reg + 6'h01 >= pvc_pkg::MISS_LIMIT) begin
                miss_reg    <= pvc_pkg::MISS_LIMIT;
                present_reg <= 1'b0; // [RULE13]
            end else begin
                miss_reg    <= miss_reg + 6'h01;
            end
        end
    end

    // status writes never reach here, so the lock bit is unwritable by design
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            hrun_reg  <= 6'h00;
            hlock_reg <= 1'b0;
        end else if (dec.line_tick) begin
            if (hrun_next == pvc_pkg::RUN_LEN) begin
                hrun_reg  <= 6'h00;
                hlock_reg <= ~hlock_reg; // [RULE14]
            end else begin
                hrun_reg  <= hrun_next;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            frun_reg     <= 6'h00;
            lines625_reg <= 1'b0;
        end else if (dec.field_end) begin
            if (frun_next == pvc_pkg::RUN_LEN) begin
                frun_reg     <= 6'h00;
                lines625_reg <= ~lines625_reg; // [RULE17]
            end else begin
                frun_reg     <= frun_next;
            end
        end
    end

    property p_hlock_on_line;
        @(posedge core_clk) disable iff (!nrst)
        $changed(hlock_reg) |-> $past(dec.line_tick);
    endproperty
    a_hlock_on_line: assert property (p_hlock_on_line) // [RULE14]
        else $error("lock bit moved without a line strobe");

    property p_present_set;
        @(posedge core_clk) disable iff (!nrst)
        dec.line_tick && dec.line_had_sync |=> present_reg;
    endproperty
    a_present_set: assert property (p_present_set) // [RULE13]
        else $error("presence not set after a synced line");
endmodule : pvc_vid_filter

//--- core/pvc_regs.sv
/*
 * configuration fields, device control and local status/field registers.
 * assumes the bus core delivers decoded accesses on core_clk, one per pulse,
 * and decoder strobes on the same clock.
 */
module pvc_regs (
    input  wire logic              core_clk,
    input  wire logic              nrst,
    input  wire pvc_pkg::pvc_req_t req,
    input  wire pvc_pkg::pvc_dec_t dec,
    output logic                   rd_valid_reg,
    output logic [31:0]            rd_data_reg,
    output logic                   chipset_compat_a_en,
    output logic                   chipset_compat_b_en,
    output logic [7:0]             int_line_reg,
    output logic [15:0]            subsys_vendor_reg,
    output logic [15:0]            subsys_id_reg,
    output logic [7:0]             capture_ctrl_reg
);
    logic        subsys_vendor_write_en;
    logic        field_even_reg;
    logic        pll_unlocked;
    logic        luma_adc_overflow;
    logic        chroma_adc_overflow;
    logic        video_present;
    logic        horiz_lock;
    logic        line_count_625;
    logic [7:0]  capt_even_reg;
    logic [7:0]  capt_odd_reg;
    logic [7:0]  decoder_status;
    logic [31:0] rd_next;
    logic        wr_cfg;
    logic        wr_loc;
    logic        st_clr;

    assign wr_cfg = req.valid && req.write && req.cfg;
    // function 1 owns its own window elsewhere; only function 0 is held here
    assign wr_loc = req.valid && req.write && !req.cfg && !req.func;
    assign st_clr = wr_loc && req.be[0] && pvc_pkg::pvc_hit(req.addr, pvc_pkg::LOC_STATUS);

    pvc_vid_filter u_filter (
        .core_clk     (core_clk),
        .nrst         (nrst),
        .dec          (dec),
        .present_reg  (video_present),
        .hlock_reg    (horiz_lock),
        .lines625_reg (line_count_625)
    );

    always_comb begin
        decoder_status                      = pvc_pkg::STATUS_RST;
        decoder_status[pvc_pkg::ST_PRESENT] = video_present;
        decoder_status[pvc_pkg::ST_LOCK]    = horiz_lock;
        decoder_status[pvc_pkg::ST_FIELD]   = field_even_reg; // [RULE15]
        decoder_status[pvc_pkg::ST_LINES]   = line_count_625;
        decoder_status[pvc_pkg::ST_PLL]     = pll_unlocked;
        decoder_status[pvc_pkg::ST_LUMA]    = luma_adc_overflow;
        decoder_status[pvc_pkg::ST_CHROMA]  = chroma_adc_overflow;
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            int_line_reg <= 8'h00;
        end else if (wr_cfg && req.be[0] && pvc_pkg::pvc_hit(req.addr, pvc_pkg::CFG_INTLAT)) begin
            int_line_reg <= req.wdata[7:0]; // [RULE4] [RULE19]
        end
    end

    // shared by both functions, so the function bit is not decoded here
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            chipset_compat_a_en    <= 1'b0;
            chipset_compat_b_en    <= 1'b0;
            subsys_vendor_write_en <= 1'b0;
        end else if (wr_cfg && req.be[0] && pvc_pkg::pvc_hit(req.addr, pvc_pkg::CFG_DEVCTL)) begin
            chipset_compat_a_en    <= req.wdata[pvc_pkg::DC_CMP_A]; // [RULE5]
            chipset_compat_b_en    <= req.wdata[pvc_pkg::DC_CMP_B]; // [RULE5]
            subsys_vendor_write_en <= req.wdata[pvc_pkg::DC_SVWE];  // [RULE6]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            subsys_vendor_reg <= 16'h0000;
            subsys_id_reg     <= 16'h0000;
        end else if (wr_cfg && pvc_pkg::pvc_hit(req.addr, pvc_pkg::CFG_SUBSYS)) begin
            if (subsys_vendor_write_en && req.be[0]) begin
                subsys_vendor_reg[7:0] <= req.wdata[7:0]; // [RULE6]
            end
            if (subsys_vendor_write_en && req.be[1]) begin
                subsys_vendor_reg[15:8] <= req.wdata[15:8]; // [RULE6]
            end
            if (req.be[2]) begin
                subsys_id_reg[7:0] <= req.wdata[23:16];
            end
            if (req.be[3]) begin
                subsys_id_reg[15:8] <= req.wdata[31:24];
            end
        end
    end

    // sticky bits: a new event in the clearing cycle wins over the clear
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            luma_adc_overflow   <= 1'b0;
            chroma_adc_overflow <= 1'b0;
            pll_unlocked        <= 1'b0;
        end else begin
            luma_adc_overflow   <= dec.luma_ovf || (luma_adc_overflow && !st_clr);     // [RULE16]
            chroma_adc_overflow <= dec.chroma_ovf || (chroma_adc_overflow && !st_clr); // [RULE16]
            pll_unlocked        <= dec.pll_unlock || (pll_unlocked && !st_clr);        // [RULE18]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            field_even_reg <= 1'b0;
        end else begin
            field_even_reg <= dec.field_even; // [RULE12] [RULE15]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            capt_even_reg <= 8'h00;
            capt_odd_reg  <= 8'h00;
        end else if (wr_loc && req.be[0]) begin
            if (pvc_pkg::pvc_hit(req.addr, pvc_pkg::LOC_CAPT_EV)) begin
                capt_even_reg <= req.wdata[7:0]; // [RULE9]
            end
            if (pvc_pkg::pvc_hit(req.addr, pvc_pkg::LOC_CAPT_OD)) begin
                capt_odd_reg <= req.wdata[7:0]; // [RULE9]
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            capture_ctrl_reg <= 8'h00;
        end else begin
            capture_ctrl_reg <= field_even_reg ? capt_even_reg : capt_odd_reg; // [RULE11]
        end
    end

    always_comb begin
        rd_next = 32'h0000_0000;
        if (req.cfg) begin
            if (pvc_pkg::pvc_hit(req.addr, pvc_pkg::CFG_INTLAT)) begin
                rd_next = {pvc_pkg::MAX_LAT_VAL, pvc_pkg::MIN_GNT_VAL, // [RULE1] [RULE2]
                           pvc_pkg::INT_PIN_VAL, int_line_reg};         // [RULE3] [RULE4]
            end else if (pvc_pkg::pvc_hit(req.addr, pvc_pkg::CFG_DEVCTL)) begin
                rd_next[pvc_pkg::DC_CMP_A] = chipset_compat_a_en;
                rd_next[pvc_pkg::DC_CMP_B] = chipset_compat_b_en;
                rd_next[pvc_pkg::DC_SVWE]  = subsys_vendor_write_en;
            end else if (pvc_pkg::pvc_hit(req.addr, pvc_pkg::CFG_SUBSYS)) begin
                rd_next = {subsys_id_reg, subsys_vendor_reg};
            end
        end else if (!req.func) begin
            // lanes 3..1 stay zero; unused words read zero as a safe choice
            if (pvc_pkg::pvc_hit(req.addr, pvc_pkg::LOC_STATUS)) begin // [RULE7] [RULE10]
                rd_next[7:0] = decoder_status; // [RULE9] [RULE12]
            end else if (pvc_pkg::pvc_hit(req.addr, pvc_pkg::LOC_CAPT_EV)) begin
                rd_next[7:0] = capt_even_reg;
            end else if (pvc_pkg::pvc_hit(req.addr, pvc_pkg::LOC_CAPT_OD)) begin
                rd_next[7:0] = capt_odd_reg;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rd_valid_reg <= 1'b0;
            rd_data_reg  <= 32'h0000_0000;
        end else begin
            rd_valid_reg <= req.valid && !req.write; // [RULE8]
            rd_data_reg  <= (req.valid && !req.write) ? rd_next : 32'h0000_0000;
        end
    end

    property p_max_lat;
        @(posedge core_clk) disable iff (!nrst)
        req.valid && !req.write && req.cfg && pvc_pkg::pvc_hit(req.addr, pvc_pkg::CFG_INTLAT)
        |=> rd_valid_reg && rd_data_reg[31:25] == 7'h28;
    endproperty
    a_max_lat: assert property (p_max_lat) // [RULE1]
        else $error("max latency field wrong");

    property p_min_gnt;
        @(posedge core_clk) disable iff (!nrst)
        req.valid && !req.write && req.cfg && pvc_pkg::pvc_hit(req.addr, pvc_pkg::CFG_INTLAT)
        |=> rd_data_reg[24:16] == 9'h010 && rd_data_reg[15:8] == 8'h01;
    endproperty
    a_min_gnt: assert property (p_min_gnt) // [RULE2]
        else $error("min grant or pin field wrong");

    property p_int_line;
        @(posedge core_clk) disable iff (!nrst)
        wr_cfg && req.be[0] && pvc_pkg::pvc_hit(req.addr, pvc_pkg::CFG_INTLAT)
        |=> int_line_reg == $past(req.wdata[7:0]);
    endproperty
    a_int_line: assert property (p_int_line) // [RULE4]
        else $error("interrupt line not stored");

    property p_devctl;
        @(posedge core_clk) disable iff (!nrst)
        wr_cfg && req.be[0] && pvc_pkg::pvc_hit(req.addr, pvc_pkg::CFG_DEVCTL)
        |=> chipset_compat_a_en == $past(req.wdata[2])
            && chipset_compat_b_en == $past(req.wdata[1]);
    endproperty
    a_devctl: assert property (p_devctl) // [RULE5]
        else $error("compat enables not stored");

    property p_svid_gate;
        @(posedge core_clk) disable iff (!nrst)
        !subsys_vendor_write_en |=> $stable(subsys_vendor_reg);
    endproperty
    a_svid_gate: assert property (p_svid_gate) // [RULE6]
        else $error("vendor id written while disabled");

    property p_read_ans;
        @(posedge core_clk) disable iff (!nrst)
        req.valid && !req.write |=> rd_valid_reg ##1 !rd_valid_reg || $past(req.valid);
    endproperty
    a_read_ans: assert property (p_read_ans) // [RULE8]
        else $error("read not answered in one cycle");

    property p_lane0;
        @(posedge core_clk) disable iff (!nrst)
        req.valid && !req.write && !req.cfg |=> rd_data_reg[31:8] == 24'h000000;
    endproperty
    a_lane0: assert property (p_lane0) // [RULE9]
        else $error("upper lanes not zero on local read");

    property p_field_sel;
        @(posedge core_clk) disable iff (!nrst)
        field_even_reg && $stable(capt_even_reg) |=> capture_ctrl_reg == $past(capt_even_reg);
    endproperty
    a_field_sel: assert property (p_field_sel) // [RULE11]
        else $error("even field value not selected");

    property p_ovf_sticky;
        @(posedge core_clk) disable iff (!nrst)
        dec.luma_ovf ##1 !st_clr |=> luma_adc_overflow;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) // [RULE16]
        else $error("luma overflow flag lost");

    property p_ovf_hold;
        @(posedge core_clk) disable iff (!nrst)
        !dec.chroma_ovf && !st_clr |=> chroma_adc_overflow == $past(chroma_adc_overflow);
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) // [RULE12]
        else $error("chroma overflow changed without cause");
endmodule : pvc_regs

//--- bench/pvc_host_model.sv
/*
 * host bridge model: issues decoded register accesses on the falling edge and
 * notes each expected read answer in exp_q. assumes the bench pops exp_q in order.
 */
module pvc_host_model (
    input  wire logic         core_clk,
    output pvc_pkg::pvc_req_t req
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [31:0] seed = 32'h00010c1a;
    logic [31:0] exp_q[$];

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    initial req = '0;

    // valid stays high between calls, so consecutive calls are back to back
    task automatic access(input logic cfg, input logic wr, input logic fn, input logic [9:0] a,
                          input logic [3:0] be, input logic [31:0] wd, input logic [31:0] ex);
        @(negedge core_clk);
        req = '{valid: 1'b1, cfg: cfg, write: wr, func: fn, addr: a, be: be, wdata: wd};
        if (!wr) begin
            exp_q.push_back(ex);
        end
    endtask : access

    // a released bus shows noise, never a stale copy of the last access
    task automatic rel();
        logic [63:0] n;
        if (req.valid === 1'b1) begin
            n = {rnd(), rnd()};
            @(negedge core_clk);
            req = pvc_pkg::pvc_req_t'({1'b0, n[48:0]});
        end
    endtask : rel
endmodule : pvc_host_model

//--- bench/tb_top.sv
/*
 * self-checking bench for the capture register bank.
 * assumes pvc_regs as top and pvc_host_model as the bus master.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic              core_clk = 1'b0;
    logic              nrst     = 1'b0;
    pvc_pkg::pvc_req_t req;
    pvc_pkg::pvc_dec_t dec      = '0;
    logic              rd_valid_reg;
    logic [31:0]       rd_data_reg;
    logic              chipset_compat_a_en;
    logic              chipset_compat_b_en;
    logic [7:0]        int_line_reg;
    logic [15:0]       subsys_vendor_reg;
    logic [15:0]       subsys_id_reg;
    logic [7:0]        capture_ctrl_reg;
    int                err_count   = 0;
    int                check_count = 0;
    int                cycles      = 0;
    logic              vid_on = 1'b0, hl = 1'b0, fe = 1'b0, l625 = 1'b0;
    logic              pll = 1'b0, luma_ov = 1'b0, chroma_ov = 1'b0;

    always #20 core_clk = ~core_clk;

    pvc_host_model h (.core_clk(core_clk), .req(req));

    pvc_regs dut (
        .core_clk            (core_clk),
        .nrst                (nrst),
        .req                 (req),
        .dec                 (dec),
        .rd_valid_reg        (rd_valid_reg),
        .rd_data_reg         (rd_data_reg),
        .chipset_compat_a_en (chipset_compat_a_en),
        .chipset_compat_b_en (chipset_compat_b_en),
        .int_line_reg        (int_line_reg),
        .subsys_vendor_reg   (subsys_vendor_reg),
        .subsys_id_reg       (subsys_id_reg),
        .capture_ctrl_reg    (capture_ctrl_reg)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        if (err_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    function automatic logic [31:0] st();
        return {24'h000000, vid_on, hl, fe, l625, 1'b0, pll, luma_ov, chroma_ov};
    endfunction : st

    task automatic rd(input logic cfg, input logic fn, input logic [9:0] a, input logic [3:0] be,
                      input logic [31:0] ex);
        h.access(cfg, 1'b0, fn, a, be, h.rnd(), ex);
    endtask : rd

    task automatic wr(input logic cfg, input logic [9:0] a, input logic [3:0] be,
                      input logic [31:0] d);
        h.access(cfg, 1'b1, 1'b0, a, be, d, 32'h00000000);
    endtask : wr

    // qualifiers carry the inverse between ticks so a late sample cannot pass
    task automatic line(input logic sync, input logic win, input int n);
        h.rel();
        repeat (n) begin
            @(negedge core_clk);
            dec.line_tick = 1'b1;
            dec.line_had_sync = sync;
            dec.line_in_window = win;
            @(negedge core_clk);
            dec.line_tick = 1'b0;
            dec.line_had_sync = ~sync;
            dec.line_in_window = ~win;
        end
    endtask : line

    task automatic field(input logic is625, input int n);
        h.rel();
        repeat (n) begin
            @(negedge core_clk);
            dec.field_end = 1'b1;
            dec.field_is_625 = is625;
            @(negedge core_clk);
            dec.field_end = 1'b0;
            dec.field_is_625 = ~is625;
        end
    endtask : field

    // every read answer is paired with the oldest note of the master
    always @(negedge core_clk) begin
        if (nrst === 1'b1 && rd_valid_reg !== 1'b0) begin
            if (h.exp_q.size() == 0) begin
                check("unrequested answer", {31'h0, rd_valid_reg}, 32'h00000000);
            end else begin
                check("read data", rd_data_reg, h.exp_q.pop_front());
            end
        end
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    initial begin
        logic [31:0] v;
        logic [31:0] w;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        nrst = 1'b1;
        rd(1'b1, 1'b0, 10'h00f, 4'hf, {7'h28, 9'h010, 8'h01, 8'h00});
        rd(1'b1, 1'b0, 10'h010, 4'hf, 32'h00000000);
        rd(1'b1, 1'b0, 10'h008, 4'hf, 32'h00000000);
        rd(1'b0, 1'b0, 10'h000, 4'hf, st());
        v = h.rnd();
        wr(1'b1, 10'h00f, 4'hf, v);
        rd(1'b1, 1'b0, 10'h00f, 4'hf, {7'h28, 9'h010, 8'h01, v[7:0]});
        wr(1'b1, 10'h00f, 4'he, ~v);
        rd(1'b1, 1'b1, 10'h00f, 4'hf, {7'h28, 9'h010, 8'h01, v[7:0]});
        w = h.rnd();
        wr(1'b1, 10'h008, 4'hf, w);
        rd(1'b1, 1'b0, 10'h008, 4'hf, {w[31:16], 16'h0000});
        wr(1'b1, 10'h010, 4'h1, 32'hffffff05);
        rd(1'b1, 1'b1, 10'h010, 4'hf, 32'h00000005);
        wr(1'b1, 10'h008, 4'hf, v);
        rd(1'b1, 1'b1, 10'h008, 4'hf, v);
        h.rel();
        check("compat a", {31'h0, chipset_compat_a_en}, 32'h00000001);
        check("compat b", {31'h0, chipset_compat_b_en}, 32'h00000000);
        check("int line", {24'h0, int_line_reg}, {24'h0, v[7:0]});
        wr(1'b1, 10'h010, 4'h1, 32'h00000002);
        wr(1'b1, 10'h008, 4'hf, w);
        h.rel();
        check("compat a", {31'h0, chipset_compat_a_en}, 32'h00000000);
        check("compat b", {31'h0, chipset_compat_b_en}, 32'h00000001);
        check("vendor", {16'h0, subsys_vendor_reg}, {16'h0, v[15:0]});
        check("subsys id", {16'h0, subsys_id_reg}, {16'h0, w[31:16]});
        rd(1'b0, 1'b0, 10'h3ff, 4'hf, 32'h00000000);
        rd(1'b0, 1'b1, 10'h000, 4'hf, 32'h00000000);
        wr(1'b0, 10'h004, 4'h1, w);
        wr(1'b0, 10'h024, 4'hf, v);
        wr(1'b0, 10'h004, 4'he, ~w);
        rd(1'b0, 1'b0, 10'h004, 4'hf, {24'h0, w[7:0]});
        rd(1'b0, 1'b0, 10'h024, 4'hf, {24'h0, v[7:0]});
        h.rel();
        repeat (3) @(negedge core_clk);
        check("capture odd", {24'h0, capture_ctrl_reg}, {24'h0, v[7:0]});
        dec.field_even = 1'b1;
        fe = 1'b1;
        repeat (3) @(negedge core_clk);
        check("capture even", {24'h0, capture_ctrl_reg}, {24'h0, w[7:0]});
        rd(1'b0, 1'b0, 10'h000, 4'hf, st());
        h.rel();
        @(negedge core_clk);
        dec.luma_ovf = 1'b1;
        luma_ov = 1'b1;
        @(negedge core_clk);
        dec.luma_ovf = 1'b0;
        rd(1'b0, 1'b0, 10'h000, 4'hf, st());
        h.rel();
        dec.chroma_ovf = 1'b1;
        dec.pll_unlock = 1'b1;
        {chroma_ov, pll} = 2'h3;
        @(negedge core_clk);
        dec.chroma_ovf = 1'b0;
        dec.pll_unlock = 1'b0;
        rd(1'b0, 1'b0, 10'h000, 4'hf, st());
        wr(1'b0, 10'h000, 4'h1, 32'h000000ff);
        {pll, luma_ov, chroma_ov} = 3'h0;
        rd(1'b0, 1'b0, 10'h000, 4'hf, st());
        line(1'b1, 1'b1, 31);
        vid_on = 1'b1;
        rd(1'b0, 1'b0, 10'h000, 4'hf, st());
        line(1'b1, 1'b1, 1);
        hl = 1'b1;
        rd(1'b0, 1'b0, 10'h000, 4'hf, st());
        line(1'b1, 1'b0, 31);
        rd(1'b0, 1'b0, 10'h000, 4'hf, st());
        line(1'b1, 1'b0, 1);
        hl = 1'b0;
        line(1'b0, 1'b0, 30);
        rd(1'b0, 1'b0, 10'h000, 4'hf, st());
        line(1'b0, 1'b0, 1);
        vid_on = 1'b0;
        rd(1'b0, 1'b0, 10'h000, 4'hf, st());
        field(1'b1, 31);
        rd(1'b0, 1'b0, 10'h000, 4'hf, st());
        field(1'b1, 1);
        l625 = 1'b1;
        rd(1'b0, 1'b0, 10'h000, 4'hf, st());
        h.rel();
        // let the answer checker take the last read before reset hides it
        @(negedge core_clk);
        nrst = 1'b0;
        l625 = 1'b0;
        repeat (2) @(negedge core_clk);
        nrst = 1'b1;
        @(negedge core_clk);
        rd(1'b1, 1'b0, 10'h00f, 4'hf, {7'h28, 9'h010, 8'h01, 8'h00});
        rd(1'b0, 1'b0, 10'h000, 4'hf, st());
        h.rel();
        repeat (3) @(negedge core_clk);
        check("answers pending", h.exp_q.size(), 32'h00000000);
        tally_and_finish();
    end
endmodule : tb_top
